// ---- verilog/sar_adc_pkg.sv ----
package sar_adc_pkg;

  // Clock and analog timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SAMPLE_TIME_NS = 1000;
  localparam int STAB_TIME_NS = 1000;
  localparam int BIT_TIME_NS = 100;

  // Least time rounded up to whole cycles, never below one
  function automatic int min_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int SAMPLE_CYC = min_cycles(SAMPLE_TIME_NS);
  localparam int STAB_CYC = min_cycles(STAB_TIME_NS);
  localparam int BIT_CYC = min_cycles(BIT_TIME_NS);

  // Converter geometry
  localparam int RES_BITS = 10;
  localparam int NUM_CH = 8;
  localparam int CH_W = 3;
  localparam int CNT_W = 16;
  localparam int PF_W = 8;
  localparam int IRQ_W = 2;

  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CHSEL = 12'h004;
  localparam logic [11:0] ADDR_PFT = 12'h008;
  localparam logic [11:0] ADDR_STATE = 12'h00c;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h010;
  localparam logic [11:0] ADDR_IRQ_CLR = 12'h014;
  localparam logic [11:0] ADDR_IRQ_EN = 12'h018;
  localparam logic [11:0] ADDR_RESULT = 12'h020;
  localparam int RESULT_IDX_LSB = 2;
  localparam int RESULT_BLK_LSB = 5;

  // Control register fields
  localparam int CTRL_W = 8;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SCAN_BIT = 1;
  localparam int CTRL_CONT_BIT = 2;
  localparam int CTRL_TRIG_LSB = 4;
  localparam int CTRL_PF_EN_BIT = 6;
  localparam int CTRL_PF_COND_BIT = 7;

  // Interrupt status bits
  localparam int IRQ_CONV_END_BIT = 0;
  localparam int IRQ_TRIG_LOST_BIT = 1;

  typedef enum logic [1:0] {TRIG_SW, TRIG_EXT, TRIG_TMR0, TRIG_TMR1}
    trig_mode_e;

endpackage

// ---- verilog/sar_adc_sequencer.sv ----
`timescale 1ns/100ps
// Contract
// - Enable starts software mode, else awaits trigger
// - Conversion start samples the selected channel
// - Hold after sampling period until bits done
// - First trial sets bit 9, half reference
// - Keep MSB if input at or above half reference
// - Then set bit 8, level by bit 9
// - Keep bit 8 at or above level
// - Repeat trial steps down to bit 0
// - Store result, then raise conversion end interrupt
// - One-shot stops after one conversion or scan
// - Continuous select repeats until enable cleared
// - Trigger modes return to standby after one-shot
// - Standby follows stabilization; triggers accepted then
// - Continuous select power-fail gates interrupt, always stores
// - Continuous scan ascends from channel 0 upward
// - Scan power-fail compares channel 0 upper byte
// - Continuous scan restarts from channel 0 unless disabled
module sar_adc_sequencer #(
  parameter int SAMPLE_CYCLES = sar_adc_pkg::SAMPLE_CYC,
  parameter int STAB_CYCLES = sar_adc_pkg::STAB_CYC,
  parameter int BIT_CYCLES = sar_adc_pkg::BIT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comp_above,
  input wire logic ext_trigger,
  input wire logic timer_trigger0,
  input wire logic timer_trigger1,
  output logic sample_hold,
  output logic [sar_adc_pkg::CH_W-1:0] analog_channel,
  output logic [sar_adc_pkg::RES_BITS-1:0] dac_code,
  output logic conversion_end_irq
);
  import sar_adc_pkg::*;

  typedef enum {ST_IDLE, ST_STAB, ST_STANDBY, ST_SAMPLE, ST_CONVERT,
    ST_STORE} seq_state_e;

  // One-hot trial bit of the approximation register
  function automatic logic [RES_BITS-1:0] trial_bit(input int idx);
    trial_bit = '0;
    trial_bit[idx] = 1'b1;
  endfunction

  // Power-fail test on the upper eight result bits
  function automatic logic pf_match(input logic [RES_BITS-1:0] res,
                                    input logic [PF_W-1:0] thr,
                                    input logic cond);
    logic [PF_W-1:0] upper;
    upper = res[RES_BITS-1 -: PF_W];
    pf_match = cond ? (upper >= thr) : (upper < thr);
  endfunction

  // Register state
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [CH_W-1:0] chsel_r, chsel_nxt;
  logic [PF_W-1:0] pft_r, pft_nxt;
  logic [IRQ_W-1:0] stat_r, stat_nxt;
  logic [IRQ_W-1:0] ien_r, ien_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic irq_r, irq_nxt;

  // Sequencer state
  seq_state_e state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [RES_BITS-1:0] sar_r, sar_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [CH_W-1:0] ch_r, ch_nxt;
  logic sh_r, sh_nxt;
  logic [RES_BITS-1:0] result_r [NUM_CH];
  logic [RES_BITS-1:0] result_nxt [NUM_CH];

  // Synchronisers for pins from the analog and timer side
  logic cmp_s1_r, cmp_s2_r;
  logic [2:0] trg_s1_r, trg_s2_r, trg_s3_r;

  logic wr_en, start_req, enable, scan, cont, pf_on, trig_hit, last_ch;
  logic store_en, conv_event, trig_lost;
  logic [CH_W-1:0] first_ch;
  logic [2:0] trg_edge;
  trig_mode_e trig_mode;

  assign enable = ctrl_r[CTRL_EN_BIT];
  assign scan = ctrl_r[CTRL_SCAN_BIT];
  assign cont = ctrl_r[CTRL_CONT_BIT];
  assign pf_on = ctrl_r[CTRL_PF_EN_BIT] & cont;
  assign trig_mode = trig_mode_e'(ctrl_r[CTRL_TRIG_LSB +: 2]);
  assign first_ch = scan ? '0 : chsel_r;
  assign last_ch = scan ? (ch_r == chsel_r) : 1'b1;
  assign trg_edge = trg_s2_r & ~trg_s3_r;

  // Trigger source chosen by mode; edges from the second stage only
  always_comb begin
    case (trig_mode)
      TRIG_EXT: trig_hit = trg_edge[0];
      TRIG_TMR0: trig_hit = trg_edge[1];
      TRIG_TMR1: trig_hit = trg_edge[2];
      default: trig_hit = 1'b0;
    endcase
  end

  // Two flops before any logic sees a pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_s1_r <= 1'b0;
      cmp_s2_r <= 1'b0;
      trg_s1_r <= '0;
      trg_s2_r <= '0;
      trg_s3_r <= '0;
    end else begin
      cmp_s1_r <= comp_above;
      cmp_s2_r <= cmp_s1_r;
      trg_s1_r <= {timer_trigger1, timer_trigger0, ext_trigger};
      trg_s2_r <= trg_s1_r;
      trg_s3_r <= trg_s2_r;
    end
  end

  // APB: one wait state, write lands on the completing edge
  assign wr_en = psel & penable & pready_r & pwrite;
  assign start_req = wr_en & (paddr == ADDR_CTRL) & pwdata[CTRL_EN_BIT];

  always_comb begin
    ctrl_nxt = ctrl_r;
    chsel_nxt = chsel_r;
    pft_nxt = pft_r;
    ien_nxt = ien_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    pready_nxt = psel & penable & ~pready_r;
    // Set wins over clear so no event is dropped
    stat_nxt = stat_r;
    if (wr_en && paddr == ADDR_IRQ_CLR) begin
      stat_nxt = stat_r & ~pwdata[IRQ_W-1:0];
    end
    stat_nxt[IRQ_CONV_END_BIT] = stat_nxt[IRQ_CONV_END_BIT] | conv_event;
    stat_nxt[IRQ_TRIG_LOST_BIT] = stat_nxt[IRQ_TRIG_LOST_BIT] | trig_lost;
    if (wr_en) begin
      if (paddr == ADDR_CTRL) begin
        ctrl_nxt = pwdata[CTRL_W-1:0];
      end else if (paddr == ADDR_CHSEL) begin
        chsel_nxt = pwdata[CH_W-1:0];
      end else if (paddr == ADDR_PFT) begin
        pft_nxt = pwdata[PF_W-1:0];
      end else if (paddr == ADDR_IRQ_EN) begin
        ien_nxt = pwdata[IRQ_W-1:0];
      end
    end
    // Read data and error are launched with pready
    if (pready_nxt) begin
      prdata_nxt = '0;
      if (paddr == ADDR_CTRL) begin
        prdata_nxt[CTRL_W-1:0] = ctrl_r;
      end else if (paddr == ADDR_CHSEL) begin
        prdata_nxt[CH_W-1:0] = chsel_r;
      end else if (paddr == ADDR_PFT) begin
        prdata_nxt[PF_W-1:0] = pft_r;
      end else if (paddr == ADDR_STATE) begin
        prdata_nxt[CH_W+3:0] = {ch_r, bit_r};
        prdata_nxt[CH_W+4] = (state_r == ST_STANDBY);
        prdata_nxt[CH_W+5] = (state_r != ST_IDLE);
      end else if (paddr == ADDR_IRQ_STAT) begin
        prdata_nxt[IRQ_W-1:0] = stat_r;
      end else if (paddr == ADDR_IRQ_CLR) begin
        prdata_nxt = '0;
      end else if (paddr == ADDR_IRQ_EN) begin
        prdata_nxt[IRQ_W-1:0] = ien_r;
      end else if (paddr[11:RESULT_BLK_LSB] ==
                   ADDR_RESULT[11:RESULT_BLK_LSB]) begin
        prdata_nxt[RES_BITS-1:0] =
          result_r[paddr[RESULT_BLK_LSB-1:RESULT_IDX_LSB]];
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
    // Registered status feeds the line, so it rises after the store
    irq_nxt = |(stat_r & ien_r);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= '0;
      chsel_r <= '0;
      pft_r <= '0;
      stat_r <= '0;
      ien_r <= '0;
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      chsel_r <= chsel_nxt;
      pft_r <= pft_nxt;
      stat_r <= stat_nxt;
      ien_r <= ien_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Sequencer: stabilize, sample, ten trials, store, then decide
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    sar_nxt = sar_r;
    bit_nxt = bit_r;
    ch_nxt = ch_r;
    store_en = 1'b0;
    conv_event = 1'b0;
    trig_lost = 1'b0;
    result_nxt = result_r;
    case (state_r)
      ST_IDLE: begin
        if (start_req) begin
          state_nxt = ST_STAB;
          cnt_nxt = '0;
        end
      end
      ST_STAB: begin
        if (cnt_r == CNT_W'(STAB_CYCLES - 1)) begin
          cnt_nxt = '0;
          ch_nxt = first_ch;
          if (trig_mode == TRIG_SW) begin
            state_nxt = ST_SAMPLE;
          end else begin
            state_nxt = ST_STANDBY;
          end
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      ST_STANDBY: begin
        // Triggers count only once stabilized
        if (trig_hit) begin
          state_nxt = ST_SAMPLE;
          ch_nxt = first_ch;
          cnt_nxt = '0;
        end
      end
      ST_SAMPLE: begin
        if (cnt_r == CNT_W'(SAMPLE_CYCLES - 1)) begin
          state_nxt = ST_CONVERT;
          sar_nxt = trial_bit(RES_BITS - 1);
          bit_nxt = 4'(RES_BITS - 1);
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      ST_CONVERT: begin
        // Full bit time lets the DAC settle and the compare sync
        if (cnt_r == CNT_W'(BIT_CYCLES - 1)) begin
          cnt_nxt = '0;
          if (!cmp_s2_r) begin
            sar_nxt = sar_r & ~trial_bit(int'(bit_r));
          end
          if (bit_r == 4'h0) begin
            state_nxt = ST_STORE;
          end else begin
            bit_nxt = bit_r - 1'b1;
            sar_nxt = sar_nxt | trial_bit(int'(bit_r) - 1);
          end
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      ST_STORE: begin
        store_en = 1'b1;
        result_nxt[ch_r] = sar_r;
        if (pf_on) begin
          conv_event = (!scan || ch_r == '0) &&
                       pf_match(sar_r, pft_r, ctrl_r[CTRL_PF_COND_BIT]);
        end else begin
          conv_event = last_ch;
        end
        cnt_nxt = '0;
        if (!last_ch) begin
          ch_nxt = ch_r + 1'b1;
          state_nxt = ST_SAMPLE;
        end else if (cont) begin
          ch_nxt = first_ch;
          state_nxt = ST_SAMPLE;
        end else if (trig_mode == TRIG_SW) begin
          state_nxt = ST_IDLE;
        end else begin
          state_nxt = ST_STANDBY;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // A trigger while busy is dropped but reported
    if (trig_hit && state_r != ST_STANDBY && state_r != ST_IDLE) begin
      trig_lost = enable;
    end
    // Abort: no store, no interrupt
    if (!enable && state_r != ST_IDLE) begin
      state_nxt = ST_IDLE;
      store_en = 1'b0;
      conv_event = 1'b0;
      result_nxt = result_r;
    end
    sh_nxt = (state_nxt == ST_SAMPLE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      sar_r <= '0;
      bit_r <= '0;
      ch_r <= '0;
      sh_r <= 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
        result_r[i] <= '0;
      end
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      sar_r <= sar_nxt;
      bit_r <= bit_nxt;
      ch_r <= ch_nxt;
      sh_r <= sh_nxt;
      result_r <= result_nxt;
    end
  end

  // Outputs straight from flops
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign sample_hold = sh_r;
  assign analog_channel = ch_r;
  assign dac_code = sar_r;
  assign conversion_end_irq = irq_r;

  // Checks beside the logic they guard
  a_sw_start: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_STAB && cnt_r == CNT_W'(STAB_CYCLES - 1) && enable &&
     trig_mode == TRIG_SW) |=> state_r == ST_SAMPLE)
    else $error("software start did not sample");
  a_sample_out: assert property (@(posedge pclk) disable iff (!presetn)
    sample_hold == (state_r == ST_SAMPLE))
    else $error("sample output mismatch");
  a_hold_convert: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_SAMPLE && state_nxt == ST_CONVERT) |->
    cnt_r == CNT_W'(SAMPLE_CYCLES - 1) ##1 !sample_hold)
    else $error("hold not entered after sampling period");
  a_msb_trial: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_CONVERT && $past(state_r) == ST_SAMPLE) |->
    (dac_code == trial_bit(RES_BITS - 1) && bit_r == 4'(RES_BITS - 1)))
    else $error("first trial is not bit 9");
  a_bit_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_CONVERT && enable && cmp_s2_r &&
     cnt_r == CNT_W'(BIT_CYCLES - 1)) |=> sar_r[$past(bit_r)])
    else $error("trial bit lost although input above level");
  a_bit_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_CONVERT && enable && !cmp_s2_r &&
     cnt_r == CNT_W'(BIT_CYCLES - 1)) |=> !sar_r[$past(bit_r)])
    else $error("trial bit kept although input below level");
  a_next_trial: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_CONVERT && enable && bit_r != 4'h0 &&
     cnt_r == CNT_W'(BIT_CYCLES - 1)) |=>
    (bit_r == $past(bit_r) - 1'b1 && sar_r[bit_r]))
    else $error("next lower trial bit not set");
  a_store_irq: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_STORE && enable && conv_event && ien_r[0] &&
     !stat_r[IRQ_CONV_END_BIT] && !irq_r) |=>
    (result_r[$past(ch_r)] == $past(sar_r) && !conversion_end_irq ##1
     conversion_end_irq))
    else $error("result or interrupt order wrong");
  a_oneshot_stop: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_STORE && last_ch && !cont) |=>
    (state_r == ST_IDLE || state_r == ST_STANDBY))
    else $error("one-shot did not stop");
  a_abort_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (!enable && state_r != ST_IDLE) |=>
    (state_r == ST_IDLE && !$rose(stat_r[IRQ_CONV_END_BIT])))
    else $error("abort did not return to idle");

endmodule

// ---- tb/sar_analog_model.sv ----
`timescale 1ns/100ps
module sar_analog_model (
  input wire logic pclk,
  input wire logic sample_hold,
  input wire logic [sar_adc_pkg::CH_W-1:0] analog_channel,
  input wire logic [sar_adc_pkg::RES_BITS-1:0] dac_code,
  input wire logic [7:0][9:0] ain,
  output logic comp_above
);
  import sar_adc_pkg::*;
  logic [RES_BITS-1:0] held_r = 10'h000;

  // Track the channel while sampling, freeze it while holding
  always_ff @(posedge pclk) begin
    if (sample_hold) begin
      held_r <= ain[analog_channel];
    end
  end

  // Ideal comparator: held input at or above the DAC level
  assign comp_above = (held_r >= dac_code);
endmodule

// ---- tb/sar_adc_sequencer_tb.sv ----
`timescale 1ns/100ps
module sar_adc_sequencer_tb;
  import sar_adc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic comp_above;
  logic [2:0] trig = 3'h0;
  logic sample_hold;
  logic [CH_W-1:0] analog_channel;
  logic [RES_BITS-1:0] dac_code;
  logic conversion_end_irq;
  logic [7:0][9:0] ain = '0;
  int fail_count = 0;
  int checks = 0;
  logic [RES_BITS-1:0] codes[$];
  logic [CH_W-1:0] samp_ch;
  logic seen_samp = 1'b0;
  logic [31:0] rd;
  logic err;
  int chs[5] = '{3, 0, 7, 1, 6};
  logic [9:0] vals[5] = '{10'h2a5, 10'h000, 10'h3ff, 10'h200, 10'h1ff};

  always #5 pclk = ~pclk;

  // Short analog timings keep the run brief; bit time leaves sync margin
  sar_adc_sequencer #(.SAMPLE_CYCLES(4), .STAB_CYCLES(4), .BIT_CYCLES(6))
    sar_adc_sequencer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comp_above(comp_above), .ext_trigger(trig[0]),
    .timer_trigger0(trig[1]), .timer_trigger1(trig[2]),
    .sample_hold(sample_hold), .analog_channel(analog_channel),
    .dac_code(dac_code), .conversion_end_irq(conversion_end_irq));

  sar_analog_model sar_analog_model_inst (.pclk(pclk),
    .sample_hold(sample_hold), .analog_channel(analog_channel),
    .dac_code(dac_code), .ain(ain), .comp_above(comp_above));

  // Trial words after hold begins, and the channel seen while sampling
  always @(negedge pclk) begin
    if (sample_hold === 1'b1) begin
      seen_samp = 1'b1;
      samp_ch = analog_channel;
    end else if (seen_samp && (codes.size() == 0 || dac_code !== codes[$]))
    begin
      codes.push_back(dac_code);
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge pclk);
  endtask

  // One APB transfer; pready and read data taken at the completing edge
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    err = pslverr;
    check("pready", {31'h0, pready}, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdchk(input string what, input logic [11:0] a,
                       input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask

  // Bounded wait for the interrupt line
  task automatic wait_irq();
    int n;
    n = 0;
    while (conversion_end_irq !== 1'b1 && n < 3000) begin
      @(negedge pclk);
      n++;
    end
    check("irq wait", {31'h0, conversion_end_irq}, 32'h1);
  endtask

  task automatic pulse(input int m);
    @(posedge pclk);
    trig[m] <= 1'b1;
    repeat (3) @(posedge pclk);
    trig[m] <= 1'b0;
  endtask

  task automatic finish_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge pclk);
    fail_count++;
    finish_test();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    tick(2);
    rdchk("ctrl rst", ADDR_CTRL, 32'h0);
    rdchk("stat rst", ADDR_IRQ_STAT, 32'h0);
    wr(ADDR_STATE, 32'h1ff);
    rdchk("state ro", ADDR_STATE, 32'h0);
    xfer(1'b0, 12'h0f0, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    wr(ADDR_PFT, 32'h1a5);
    rdchk("pft width", ADDR_PFT, 32'ha5);
    rdchk("clr reads 0", ADDR_IRQ_CLR, 32'h0);
    wr(ADDR_IRQ_EN, 32'h1);
    // Software one-shot over boundary codes on several channels
    for (int i = 0; i < 5; i++) begin
      ain[chs[i]] = vals[i];
      wr(ADDR_CHSEL, 32'(chs[i]));
      wr(ADDR_IRQ_CLR, 32'h3);
      codes.delete();
      seen_samp = 1'b0;
      wr(ADDR_CTRL, 32'h1);
      wait_irq();
      rdchk("result", ADDR_RESULT + 12'(4 * chs[i]), 32'(vals[i]));
      check("msb trial", 32'(codes[0]), 32'h200);
      check("bit8 trial", 32'(codes[1]), vals[i][9] ? 32'h300 : 32'h100);
      check("sampled ch", 32'(samp_ch), 32'(chs[i]));
      xfer(1'b0, ADDR_STATE, 32'h0);
      check("busy", 32'(rd[8]), 32'h0);
    end
    // Masked event stays sticky, line follows the enable
    wr(ADDR_IRQ_CLR, 32'h3);
    wr(ADDR_IRQ_EN, 32'h0);
    wr(ADDR_CTRL, 32'h1);
    tick(200);
    check("masked", {31'h0, conversion_end_irq}, 32'h0);
    rdchk("sticky", ADDR_IRQ_STAT, 32'h1);
    wr(ADDR_IRQ_EN, 32'h1);
    tick(3);
    check("unmasked", {31'h0, conversion_end_irq}, 32'h1);
    wr(ADDR_IRQ_CLR, 32'h1);
    tick(3);
    check("cleared", {31'h0, conversion_end_irq}, 32'h0);
    // External and both timer triggers wait in standby
    for (int m = 1; m < 4; m++) begin
      ain[5] = 10'(m * 100);
      wr(ADDR_CHSEL, 32'h5);
      wr(ADDR_CTRL, 32'h1 | 32'(m << 4));
      tick(30);
      xfer(1'b0, ADDR_STATE, 32'h0);
      check("standby", 32'(rd[7]), 32'h1);
      rdchk("no start", ADDR_IRQ_STAT, 32'h0);
      pulse(m - 1);
      wait_irq();
      rdchk("trig result", ADDR_RESULT + 12'h014, 32'(m * 100));
      tick(30);
      xfer(1'b0, ADDR_STATE, 32'h0);
      check("back standby", 32'(rd[7]), 32'h1);
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_IRQ_CLR, 32'h3);
    end
    // One-shot scan of channels 0 to 2
    ain[2:0] = {10'h0c3, 10'h2e1, 10'h17f};
    wr(ADDR_CHSEL, 32'h2);
    wr(ADDR_CTRL, 32'h3);
    wait_irq();
    tick(300);
    for (int c = 0; c < 3; c++) begin
      rdchk("scan result", ADDR_RESULT + 12'(4 * c), 32'(ain[c]));
    end
    xfer(1'b0, ADDR_STATE, 32'h0);
    check("scan stop", 32'(rd[8]), 32'h0);
    // Power-fail gating: select on channel 0, then scan up to channel 1
    for (int i = 0; i < 2; i++) begin
      ain[0] = 10'h3ff;
      ain[1] = 10'(10'h155 + i);
      wr(ADDR_PFT, 32'h80);
      wr(ADDR_CHSEL, 32'(i));
      wr(ADDR_IRQ_CLR, 32'h3);
      wr(ADDR_CTRL, i ? 32'hc7 : 32'hc5);
      wait_irq();
      wr(ADDR_IRQ_CLR, 32'h1);
      tick(3);
      wait_irq();
      ain[0] = 10'h005;
      tick(300);
      wr(ADDR_IRQ_CLR, 32'h1);
      tick(400);
      rdchk("pf gated", ADDR_IRQ_STAT, 32'h0);
      rdchk("pf stored", ADDR_RESULT, 32'h5);
      if (i) begin
        rdchk("scan ch1", ADDR_RESULT + 12'h004, 32'(ain[1]));
      end
      wr(ADDR_CTRL, 32'h0);
      tick(5);
      xfer(1'b0, ADDR_STATE, 32'h0);
      check("stopped", 32'(rd[8]), 32'h0);
    end
    // Abort mid conversion leaves no result and no event
    ain[4] = 10'h123;
    wr(ADDR_CHSEL, 32'h4);
    wr(ADDR_IRQ_CLR, 32'h3);
    wr(ADDR_CTRL, 32'h1);
    tick(25);
    wr(ADDR_CTRL, 32'h0);
    tick(200);
    rdchk("abort result", ADDR_RESULT + 12'h010, 32'h0);
    rdchk("abort stat", ADDR_IRQ_STAT, 32'h0);
    finish_test();
  end
endmodule
